// File: hw/dtu_core.sv
// Data transfer execution unit of an 8-bit core.
module dtu_core
    import dtu_pkg::*;
#(
    parameter bit HAS_UPPER = 1'b1
) (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Instruction issue.
    input wire logic issue_in,
    input wire logic [3:0] op_in,
    input wire logic [1:0] src_mode_in,
    input wire logic [1:0] dst_mode_in,
    input wire logic [7:0] src_byte_in,
    input wire logic [7:0] dst_byte_in,
    input wire logic [15:0] imm16_in,
    input wire logic [2:0] reg_sel_in,
    input wire logic ptr_sel_in,
    input wire logic [15:0] next_pc_in,
    output logic ready_out,
    output logic done_out,
    // Function space access.
    output logic func_we_out,
    output logic [7:0] func_addr_out,
    output logic [7:0] func_wdata_out,
    input wire logic [7:0] func_rdata_in,
    // External data memory.
    output logic [7:0] ext_addr_lo_out,
    output logic [7:0] ext_addr_hi_out,
    output logic ext_addr_hi_en_out,
    output logic [7:0] ext_wdata_out,
    output logic ext_wdata_en_out,
    input wire logic [7:0] ext_rdata_in,
    output logic ext_rd_strobe_n_out,
    output logic ext_wr_strobe_n_out,
    // Program memory.
    output logic [15:0] code_addr_out,
    input wire logic [7:0] code_rdata_in,
    output logic program_store_read_strobe_n_out,
    // Architectural state view.
    output logic [7:0] accumulator_out,
    output logic [7:0] stack_pointer_out,
    output logic [15:0] data_pointer_out
);
    default clocking dtu_cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    // =========================================================
    // State.
    // =========================================================
    typedef enum logic [1:0] {
        DTU_ST_IDLE = 2'b00,
        DTU_ST_EXEC = 2'b01
    } dtu_state_e;

    dtu_state_e state;
    logic [3:0] op;
    logic [1:0] smode;
    logic [1:0] dmode;
    logic [7:0] sbyte;
    logic [7:0] dbyte;
    logic [15:0] imm;
    logic [2:0] rsel;
    logic psel;
    logic [15:0] npc;
    logic [7:0] accumulator;
    logic [7:0] stack_pointer;
    logic [15:0] data_pointer;
    logic [15:0] pin_sync1;
    logic [15:0] pin_sync2;
    logic [7:0] src_keep;

    // =========================================================
    // Operand decoding.
    // =========================================================
    function automatic logic [7:0] ea(input logic [1:0] mode,
                                      input logic [7:0] opnd,
                                      input logic [7:0] ptr_val,
                                      input logic [7:0] reg_addr);
        case (mode)
            DTU_MODE_DIR: ea = opnd;
            DTU_MODE_IND: ea = ptr_val;
            DTU_MODE_REG: ea = reg_addr;
            default: ea = opnd;
        endcase
    endfunction

    function automatic logic is_func(input logic [1:0] mode,
                                     input logic [7:0] addr);
        is_func = (mode == DTU_MODE_DIR) && (addr >= FUNC_SPACE_BASE);
    endfunction

    logic start;
    logic mc_end;
    logic two_mc;
    logic [7:0] ptr_addr;
    logic [7:0] reg_addr;
    logic [7:0] ptr_val;
    logic [7:0] rd_a_addr;
    logic [7:0] rd_b_addr;
    logic [7:0] ram_a;
    logic [7:0] ram_b;
    logic [7:0] src_ea;
    logic [7:0] dst_ea;
    logic src_func;
    logic dst_func;
    logic [7:0] src_val;
    logic [7:0] dst_val;
    logic [7:0] stack_next;
    logic is_ext;
    logic is_ext_wide;
    logic is_ext_wr;
    logic is_tbl;
    logic [15:0] tbl_addr;
    assign ready_out = (state == DTU_ST_IDLE);
    assign start = issue_in && ready_out;
    // Register bank R0..R7 lives in low RAM; pointer register is R0/R1.
    assign reg_addr = {5'h00, rsel};
    assign ptr_addr = {7'h00, psel};
    assign ptr_val = ram_b;
    assign src_ea = ea(smode, sbyte, ptr_val, reg_addr);
    assign dst_ea = ea(dmode, dbyte, ptr_val, reg_addr);
    assign src_func = is_func(smode, src_ea);
    assign dst_func = is_func(dmode, dst_ea);
    assign stack_next = stack_pointer + 8'h01;

    // Stack is always RAM, reached through the stack pointer.
    assign rd_a_addr = (op == DTU_OP_POP) ? stack_pointer :
                       (op == DTU_OP_MOV_A_SRC ||
                        op == DTU_OP_MOV_DST_SRC ||
                        op == DTU_OP_PUSH) ? src_ea : dst_ea;
    assign rd_b_addr = ptr_addr;
    assign src_val = (smode == DTU_MODE_IMM) ? sbyte :
                     src_func ? func_rdata_in : ram_a;
    assign dst_val = dst_func ? func_rdata_in : ram_a;

    assign is_ext = (op >= DTU_OP_XRD_RI) && (op <= DTU_OP_XWR_DP);
    assign is_ext_wide = (op == DTU_OP_XRD_DP) || (op == DTU_OP_XWR_DP);
    assign is_ext_wr = (op == DTU_OP_XWR_RI) || (op == DTU_OP_XWR_DP);
    assign is_tbl = (op == DTU_OP_TBL_DP) || (op == DTU_OP_TBL_PC);

    // Pointer table: data pointer plus unsigned accumulator.
    // Counter table: already advanced counter plus accumulator.
    assign tbl_addr = ((op == DTU_OP_TBL_DP) ? data_pointer : npc) +
                      {8'h00, accumulator};

    // Two-cycle group versus one-cycle group.
    assign two_mc = (op_in == DTU_OP_MOV_DST_SRC) ||
                    (op_in == DTU_OP_LOAD_DP) || (op_in == DTU_OP_PUSH) ||
                    (op_in == DTU_OP_POP) || (op_in >= DTU_OP_XRD_RI);

    dtu_cycle_timer u_timer (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .start_in(start),
        .two_mc_in(two_mc),
        .mc_end_out(mc_end),
        .last_out(),
        .busy_out()
    );

    // =========================================================
    // Write-back selection.
    // =========================================================
    logic ram_we;
    logic [7:0] ram_waddr;
    logic [7:0] ram_wdata;
    logic fin;

    assign fin = (state == DTU_ST_EXEC) && mc_end;
    assign done_out = fin;

    always_comb begin
        ram_we = 1'b0;
        ram_waddr = dst_ea;
        ram_wdata = src_val;
        func_we_out = 1'b0;
        func_addr_out = src_ea;
        func_wdata_out = src_val;
        case (op)
            DTU_OP_MOV_DST_A, DTU_OP_XCH, DTU_OP_LOW_NIBBLE_EXCHANGE: begin
                func_addr_out = dst_ea;
                func_we_out = fin && dst_func;
                ram_we = fin && !dst_func;
                ram_wdata = (op == DTU_OP_LOW_NIBBLE_EXCHANGE) ?
                            {dst_val[7:4], accumulator[3:0]} : accumulator;
                func_wdata_out = ram_wdata;
            end
            DTU_OP_MOV_DST_SRC, DTU_OP_POP: begin
                // For a move the shared port turns to the target on the write edge; for pop it stays on the target.
                func_addr_out = (op == DTU_OP_POP) ? dbyte :
                                (fin && dst_func) ? dst_ea : src_ea;
                // Copy any location to any other.
                ram_waddr = (op == DTU_OP_POP) ? dbyte : dst_ea;
                ram_wdata = (op == DTU_OP_POP) ? ram_a :
                            src_func ? src_keep : src_val;
                func_wdata_out = ram_wdata;
                func_we_out = fin && ram_waddr >= FUNC_SPACE_BASE &&
                              dmode == DTU_MODE_DIR;
                ram_we = fin && !func_we_out;
            end
            DTU_OP_PUSH: begin
                // Write lands on the already incremented slot.
                ram_waddr = stack_next;
                ram_we = fin;
            end
            default: ram_we = 1'b0;
        endcase
    end

    dtu_ram #(
        .HAS_UPPER(HAS_UPPER)
    ) u_ram (
        .core_clk_in(core_clk_in),
        .we_in(ram_we),
        .waddr_in(ram_waddr),
        .wdata_in(ram_wdata),
        .raddr_a_in(rd_a_addr),
        .rdata_a_out(ram_a),
        .raddr_b_in(rd_b_addr),
        .rdata_b_out(ram_b)
    );

    // =========================================================
    // External and program memory pins.
    // =========================================================
    logic ext_act;
    assign ext_act = (state == DTU_ST_EXEC) && is_ext;
    // Address from pointer register or data pointer.
    assign ext_addr_lo_out = is_ext_wide ? data_pointer[7:0] : ptr_val;
    assign ext_addr_hi_out = data_pointer[15:8];
    // Upper port used only by the wide form.
    assign ext_addr_hi_en_out = ext_act && is_ext_wide;
    // Accumulator is the sole data source.
    assign ext_wdata_out = accumulator;
    assign ext_wdata_en_out = ext_act && is_ext_wr;
    // Strobes idle unless an external move runs.
    assign ext_rd_strobe_n_out = !(ext_act && !is_ext_wr);
    assign ext_wr_strobe_n_out = !(ext_act && is_ext_wr);
    // Table reads only ever read program memory.
    assign code_addr_out = tbl_addr;
    assign program_store_read_strobe_n_out =
        !((state == DTU_ST_EXEC) && is_tbl);

    // =========================================================
    // Sequencing and architectural registers.
    // =========================================================
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_sync1 <= 16'h0000;
            pin_sync2 <= 16'h0000;
            src_keep <= 8'h00;
        end else begin
            pin_sync1 <= {code_rdata_in, ext_rdata_in};
            pin_sync2 <= pin_sync1;
            src_keep <= src_val;
        end
    end
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= DTU_ST_IDLE;
            op <= 4'h0;
            smode <= 2'h0;
            dmode <= 2'h0;
            sbyte <= 8'h00;
            dbyte <= 8'h00;
            imm <= 16'h0000;
            rsel <= 3'h0;
            psel <= 1'b0;
            npc <= 16'h0000;
        end else begin
            case (state)
                DTU_ST_IDLE: begin
                    if (start) begin
                        state <= DTU_ST_EXEC;
                        op <= op_in;
                        smode <= src_mode_in;
                        dmode <= dst_mode_in;
                        sbyte <= src_byte_in;
                        dbyte <= dst_byte_in;
                        imm <= imm16_in;
                        rsel <= reg_sel_in;
                        psel <= ptr_sel_in;
                        npc <= next_pc_in;
                    end
                end
                DTU_ST_EXEC: begin
                    if (mc_end) begin
                        state <= DTU_ST_IDLE;
                    end
                end
                default: begin
                    state <= DTU_ST_IDLE;
                end
            endcase
        end
    end

    logic [7:0] next_acc;
    always_comb begin
        next_acc = accumulator;
        case (op)
            DTU_OP_MOV_A_SRC: next_acc = src_val;
            DTU_OP_XCH: next_acc = dst_val;
            DTU_OP_LOW_NIBBLE_EXCHANGE: next_acc = {accumulator[7:4], dst_val[3:0]};
            DTU_OP_XRD_RI, DTU_OP_XRD_DP: next_acc = pin_sync2[7:0];
            DTU_OP_TBL_DP, DTU_OP_TBL_PC: next_acc = pin_sync2[15:8];
            default: next_acc = accumulator;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            accumulator <= 8'h00;
            stack_pointer <= SP_RESET;
            data_pointer <= 16'h0000;
        end else if (fin) begin
            accumulator <= next_acc;
            if (op == DTU_OP_LOAD_DP) begin
                data_pointer <= imm;
            end
            if (op == DTU_OP_PUSH) begin
                stack_pointer <= stack_next;
            end else if (op == DTU_OP_POP) begin
                stack_pointer <= stack_pointer - 8'h01;
            end
        end
    end

    assign accumulator_out = accumulator;
    assign stack_pointer_out = stack_pointer;
    assign data_pointer_out = data_pointer;
    // =========================================================
    // Checks.
    // =========================================================
    sequence s_issue_two;
        start && two_mc;
    endsequence
    a_two_cycle_done: assert property (
        s_issue_two |-> !done_out [*8] ##17 done_out)
        else $error("two-cycle instruction ended at wrong time");
    a_one_cycle_done: assert property (
        start && !two_mc |-> ##12 done_out)
        else $error("one-cycle instruction ended at wrong time");
    a_push_sp_inc: assert property (
        fin && op == DTU_OP_PUSH |=> stack_pointer == $past(stack_next))
        else $error("push did not raise the stack pointer");
    a_pop_sp_dec: assert property (
        fin && op == DTU_OP_POP |=>
        stack_pointer == $past(stack_pointer) - 8'h01)
        else $error("pop did not lower the stack pointer");
    a_dp_load: assert property (
        fin && op == DTU_OP_LOAD_DP |=> data_pointer == $past(imm))
        else $error("data pointer not loaded");
    a_mov_acc_kept: assert property (
        fin && op == DTU_OP_MOV_DST_SRC |=> $stable(accumulator))
        else $error("direct move changed the accumulator");
    a_strobe_idle: assert property (
        !ext_act |-> ext_rd_strobe_n_out && ext_wr_strobe_n_out)
        else $error("external strobe active outside external move");
    a_hi_port_free: assert property (
        ext_act && !is_ext_wide |-> !ext_addr_hi_en_out)
        else $error("upper port driven by narrow access");
    a_low_nibble_exchange_upper: assert property (
        fin && op == DTU_OP_LOW_NIBBLE_EXCHANGE |=>
        accumulator[7:4] == $past(accumulator[7:4]))
        else $error("nibble exchange changed upper nibble");
endmodule

// File: pkg/dtu_pkg.sv
// Shared constants and types of the data transfer unit.
// Notes on behaviour
// - Direct move between locations, accumulator untouched.
// - Internal moves take one or two cycles.
// - Load sixteen-bit immediate into data pointer.
// - Push increments stack pointer, then writes.
// - Pop reads stack, then decrements pointer.
// - Stack reached indirectly, never function space.
// - Missing upper RAM drops pushes, pops undefined.
// - Byte exchange swaps accumulator and operand.
// - Nibble exchange swaps low nibbles only.
// - External address from pointer register or pointer.
// - Sixteen-bit access drives upper address port.
// - External accesses take two machine cycles.
// - Accumulator is the only external data end.
// - External strobes idle outside external moves.
// - Table reads use program strobe, never write.
// - Pointer table read at pointer plus accumulator.
// - Counter table read at next address plus accumulator.
package dtu_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned REF_HZ = 12_000_000;
    localparam int unsigned OSC_PER_MC = 12;
    // Machine cycle length in core clocks (one microsecond at 12 MHz).
    localparam int unsigned MC_CLKS = OSC_PER_MC;
    localparam logic [7:0] SP_RESET = 8'h07;
    localparam logic [7:0] FUNC_SPACE_BASE = 8'h80;
    localparam int unsigned LOW_RAM_BYTES = 128;

    typedef enum logic [3:0] {
        DTU_OP_MOV_A_SRC = 4'h0,
        DTU_OP_MOV_DST_A = 4'h1,
        DTU_OP_MOV_DST_SRC = 4'h2,
        DTU_OP_LOAD_DP = 4'h3,
        DTU_OP_PUSH = 4'h4,
        DTU_OP_POP = 4'h5,
        DTU_OP_XCH = 4'h6,
        DTU_OP_LOW_NIBBLE_EXCHANGE = 4'h7,
        DTU_OP_XRD_RI = 4'h8,
        DTU_OP_XWR_RI = 4'h9,
        DTU_OP_XRD_DP = 4'hA,
        DTU_OP_XWR_DP = 4'hB,
        DTU_OP_TBL_DP = 4'hC,
        DTU_OP_TBL_PC = 4'hD
    } dtu_op_e;

    typedef enum logic [1:0] {
        DTU_MODE_DIR = 2'h0,
        DTU_MODE_IND = 2'h1,
        DTU_MODE_REG = 2'h2,
        DTU_MODE_IMM = 2'h3
    } dtu_mode_e;
endpackage

// File: hw/dtu_cycle_timer.sv
// Machine cycle timer: counts execution length of one instruction.
module dtu_cycle_timer
    import dtu_pkg::*;
#(
    parameter int unsigned MC_LEN = MC_CLKS
) (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Control.
    input wire logic start_in,
    input wire logic two_mc_in,
    // Status.
    output logic mc_end_out,
    output logic last_out,
    output logic busy_out
);
    localparam int W = $clog2(2 * MC_LEN + 1);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic [W-1:0] span;
    logic busy;

    // Each machine cycle spans twelve clocks of the core.
    assign span = two_mc_in ? W'(2 * MC_LEN) : W'(MC_LEN);
    assign next_cnt = start_in ? span - W'(1) : cnt - W'(1);
    assign mc_end_out = busy && (cnt == W'(0));
    assign last_out = mc_end_out;
    assign busy_out = busy;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt <= '0;
            busy <= 1'b0;
        end else if (start_in) begin
            cnt <= next_cnt;
            busy <= 1'b1;
        end else if (busy) begin
            cnt <= next_cnt;
            busy <= (cnt != W'(0));
        end
    end
endmodule

// File: hw/dtu_ram.sv
// Internal data RAM with optional upper half.
module dtu_ram
    import dtu_pkg::*;
#(
    parameter bit HAS_UPPER = 1'b1
) (
    // Clock.
    input wire logic core_clk_in,
    // Write port.
    input wire logic we_in,
    input wire logic [7:0] waddr_in,
    input wire logic [7:0] wdata_in,
    // Read ports.
    input wire logic [7:0] raddr_a_in,
    output logic [7:0] rdata_a_out,
    input wire logic [7:0] raddr_b_in,
    output logic [7:0] rdata_b_out
);
    logic [7:0] mem [0:255];
    logic wr_ok;

    // Without upper RAM, writes above the lower half vanish.
    assign wr_ok = HAS_UPPER || (waddr_in < 8'(LOW_RAM_BYTES));
    // Reads there return whatever the array holds, i.e. undefined.
    assign rdata_a_out = mem[raddr_a_in];
    assign rdata_b_out = mem[raddr_b_in];

    always_ff @(posedge core_clk_in) begin
        if (we_in && wr_ok) begin
            mem[waddr_in] <= wdata_in;
        end
    end
endmodule

// File: dv/dtu_ext_mem_model.sv
// Behavioural external data RAM and program memory facing the core.
module dtu_ext_mem_model (
    // Clock.
    input wire logic clk_in,
    // External data memory.
    input wire logic [7:0] addr_lo_in,
    input wire logic [7:0] addr_hi_in,
    input wire logic addr_hi_en_in,
    input wire logic [7:0] wdata_in,
    input wire logic rd_strobe_n_in,
    input wire logic wr_strobe_n_in,
    output logic [7:0] rdata_out,
    // Program memory.
    input wire logic [15:0] code_addr_in,
    input wire logic prog_strobe_n_in,
    output logic [7:0] code_rdata_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [0:65535];
    logic [15:0] addr;
    // Narrow accesses leave the upper port free, so only low lines count.
    assign addr = {addr_hi_en_in ? addr_hi_in : 8'h00, addr_lo_in};
    initial rdata_out = 8'h00;
    initial code_rdata_out = 8'h00;
    // Released data lines toggle every cycle instead of holding a value.
    always @(posedge clk_in) begin
        if (!wr_strobe_n_in) begin
            mem[addr] <= wdata_in;
        end
        rdata_out <= !rd_strobe_n_in ? mem[addr] : ~rdata_out;
        // Program memory is read-only and answers only under its strobe.
        code_rdata_out <= !prog_strobe_n_in ?
            (code_addr_in[7:0] ^ code_addr_in[15:8] ^ 8'h5A) : ~code_rdata_out;
    end
endmodule

// File: dv/tb_top.sv
// Self-checking bench of the data transfer unit.
module tb_top;
    import dtu_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_n = 0, issue = 0, ps = 0, ext_op = 0;
    logic [3:0] op = 0;
    logic [1:0] sm = 0, dm = 0;
    logic [2:0] rs = 0;
    logic [7:0] sb = 0, db = 0, frd, erd, crd, acc, sp, v, w;
    logic [7:0] fa, fwd, elo, ehi, ewd;
    logic [15:0] imm = 0, npc = 0, ca, dp;
    logic rdy, done, fwe, hen, wen, rdn, wrn, psn;
    logic [7:0] special_function_space [0:255];
    logic [7:0] idx [0:2];
    logic [31:0] lfsr = 32'h0ED9;
    int err_count = 0, checks_done = 0;

    // ==========================================================
    // Clock, special space and far side
    always #10 clk = ~clk;
    always @(posedge clk) if (fwe) special_function_space[fa] <= fwd;
    assign frd = special_function_space[fa];

    dtu_core #(.HAS_UPPER(1'b1)) u_dtu_core (
        .core_clk_in(clk), .rst_n_in(rst_n), .issue_in(issue),
        .op_in(op), .src_mode_in(sm), .dst_mode_in(dm),
        .src_byte_in(sb), .dst_byte_in(db), .imm16_in(imm),
        .reg_sel_in(rs), .ptr_sel_in(ps), .next_pc_in(npc),
        .ready_out(rdy), .done_out(done), .func_we_out(fwe),
        .func_addr_out(fa), .func_wdata_out(fwd), .func_rdata_in(frd),
        .ext_addr_lo_out(elo), .ext_addr_hi_out(ehi),
        .ext_addr_hi_en_out(hen), .ext_wdata_out(ewd),
        .ext_wdata_en_out(wen), .ext_rdata_in(erd),
        .ext_rd_strobe_n_out(rdn), .ext_wr_strobe_n_out(wrn),
        .code_addr_out(ca), .code_rdata_in(crd),
        .program_store_read_strobe_n_out(psn), .accumulator_out(acc),
        .stack_pointer_out(sp), .data_pointer_out(dp));

    dtu_ext_mem_model u_dtu_ext_mem_model (
        .clk_in(clk), .addr_lo_in(elo), .addr_hi_in(ehi),
        .addr_hi_en_in(hen), .wdata_in(ewd), .rd_strobe_n_in(rdn),
        .wr_strobe_n_in(wrn), .rdata_out(erd), .code_addr_in(ca),
        .prog_strobe_n_in(psn), .code_rdata_out(crd));

    // ==========================================================
    // Helpers
    function automatic logic [7:0] rnd8();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[7:0];
    endfunction

    function automatic logic [7:0] code_byte(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Issues one instruction and checks its length in machine cycles.
    task automatic run(input logic [3:0] o, input logic [1:0] s,
                       input logic [1:0] d, input logic [7:0] b1,
                       input logic [7:0] b2, input int mc);
        int n;
        while (rdy !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        op = o;
        sm = s;
        dm = d;
        sb = b1;
        db = b2;
        ext_op = (o >= 4'h8 && o <= 4'hB);
        issue = 1'b1;
        @(posedge clk);
        #1;
        issue = 1'b0;
        // The edge that takes the request is the first cycle.
        n = 1;
        while (done !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("cycles", 16'(mc * MC_CLKS), 16'(n));
        @(posedge clk);
        #1;
        ext_op = 1'b0;
    endtask

    task automatic mov_a(input logic [1:0] s, input logic [7:0] b);
        run(DTU_OP_MOV_A_SRC, s, DTU_MODE_DIR, b, 8'h00, 1);
    endtask

    task test_done;
        if (err_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Strobes of the external data bus must idle outside its moves.
    always @(posedge clk) begin
        if (rst_n && !ext_op) chk("ext strobes", 16'h3, {14'h0, rdn, wrn});
    end

    initial begin
        #300us;
        err_count++;
        test_done();
    end

    // ==========================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        #1;
        rst_n = 1'b1;
        chk("acc reset", 16'h0000, {8'h00, acc});
        chk("sp reset", {8'h00, SP_RESET}, {8'h00, sp});
        chk("dp reset", 16'h0000, dp);
        v = rnd8();
        w = ~v;
        mov_a(DTU_MODE_IMM, v);
        chk("mov a imm", {8'h00, v}, {8'h00, acc});
        run(DTU_OP_MOV_DST_A, DTU_MODE_DIR, DTU_MODE_DIR, 8'h00, 8'h30, 1);
        run(DTU_OP_MOV_DST_SRC, DTU_MODE_DIR, DTU_MODE_DIR, 8'h30, 8'h31, 2);
        run(DTU_OP_MOV_DST_SRC, DTU_MODE_IMM, DTU_MODE_DIR, w, 8'h90, 2);
        chk("acc kept", {8'h00, v}, {8'h00, acc});
        chk("func write", {8'h00, w}, {8'h00, special_function_space[8'h90]});
        mov_a(DTU_MODE_IMM, w);
        mov_a(DTU_MODE_DIR, 8'h31);
        chk("dir copy", {8'h00, v}, {8'h00, acc});
        run(DTU_OP_PUSH, DTU_MODE_DIR, DTU_MODE_DIR, 8'h31, 8'h00, 2);
        chk("sp push", 16'h0008, {8'h00, sp});
        mov_a(DTU_MODE_IMM, w);
        mov_a(DTU_MODE_DIR, 8'h08);
        chk("stack byte", {8'h00, v}, {8'h00, acc});
        run(DTU_OP_POP, DTU_MODE_DIR, DTU_MODE_DIR, 8'h00, 8'h40, 2);
        chk("sp pop", 16'h0007, {8'h00, sp});
        mov_a(DTU_MODE_DIR, 8'h40);
        chk("pop byte", {8'h00, v}, {8'h00, acc});
        mov_a(DTU_MODE_IMM, w);
        run(DTU_OP_XCH, DTU_MODE_DIR, DTU_MODE_DIR, 8'h30, 8'h30, 1);
        chk("xch acc", {8'h00, v}, {8'h00, acc});
        mov_a(DTU_MODE_DIR, 8'h30);
        chk("xch byte", {8'h00, w}, {8'h00, acc});
        run(DTU_OP_MOV_DST_SRC, DTU_MODE_IMM, DTU_MODE_DIR, 8'h31, 8'h00, 2);
        ps = 1'b0;
        run(DTU_OP_LOW_NIBBLE_EXCHANGE, DTU_MODE_IND, DTU_MODE_IND, 8'h00, 8'h00, 1);
        chk("low_nibble_exchange acc", {8'h00, w[7:4], v[3:0]}, {8'h00, acc});
        mov_a(DTU_MODE_DIR, 8'h31);
        chk("low_nibble_exchange byte", {8'h00, v[7:4], w[3:0]}, {8'h00, acc});
        for (int i = 0; i < 6; i++) begin
            v = rnd8();
            w = rnd8();
            imm = {rnd8() | 8'h01, rnd8()};
            run(DTU_OP_LOAD_DP, DTU_MODE_IMM, DTU_MODE_IMM, 8'h00, 8'h00, 2);
            chk("dp load", imm, dp);
            mov_a(DTU_MODE_IMM, v);
            run(DTU_OP_XWR_DP, DTU_MODE_IND, DTU_MODE_IND, 8'h00, 8'h00, 2);
            chk("wide write", {8'h00, v}, {8'h00, u_dtu_ext_mem_model.mem[imm]});
            mov_a(DTU_MODE_IMM, ~v);
            run(DTU_OP_XRD_DP, DTU_MODE_IND, DTU_MODE_IND, 8'h00, 8'h00, 2);
            chk("wide read", {8'h00, v}, {8'h00, acc});
            run(DTU_OP_MOV_DST_SRC, DTU_MODE_IMM, DTU_MODE_DIR, w, 8'h01, 2);
            ps = 1'b1;
            rs = 3'h1;
            mov_a(DTU_MODE_REG, 8'h00);
            chk("reg read", {8'h00, w}, {8'h00, acc});
            mov_a(DTU_MODE_IMM, ~v);
            run(DTU_OP_XWR_RI, DTU_MODE_IND, DTU_MODE_IND, 8'h00, 8'h00, 2);
            chk("narrow write", {8'h00, ~v}, {8'h00, u_dtu_ext_mem_model.mem[{8'h00, w}]});
            mov_a(DTU_MODE_IMM, v);
            run(DTU_OP_XRD_RI, DTU_MODE_IND, DTU_MODE_IND, 8'h00, 8'h00, 2);
            chk("narrow read", {8'h00, ~v}, {8'h00, acc});
        end
        idx[0] = 8'h00;
        idx[1] = 8'hFF;
        idx[2] = rnd8();
        for (int i = 0; i < 3; i++) begin
            mov_a(DTU_MODE_IMM, idx[i]);
            run(DTU_OP_TBL_DP, DTU_MODE_IND, DTU_MODE_IND, 8'h00, 8'h00, 2);
            chk("dp table", {8'h00, code_byte(imm + {8'h00, idx[i]})}, {8'h00, acc});
            npc = {rnd8(), rnd8()};
            mov_a(DTU_MODE_IMM, idx[i]);
            run(DTU_OP_TBL_PC, DTU_MODE_IND, DTU_MODE_IND, 8'h00, 8'h00, 2);
            chk("pc table", {8'h00, code_byte(npc + {8'h00, idx[i]})}, {8'h00, acc});
        end
        test_done();
    end
endmodule
